// ---- rtl/gcr_pkg.sv ----
package gcr_pkg;

   // ------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_CLK_CTRL  = 8'hf3;
   localparam logic [7:0] IDX_LIU_RST   = 8'hf5;
   localparam logic [7:0] IDX_FRM_RST   = 8'hf6;
   localparam logic [7:0] IDX_STATUS    = 8'hf7;
   localparam logic [7:0] IDX_ID        = 8'hf8;

   // ------------------------------------------------------------------
   // Field positions of the clock control register.
   // ------------------------------------------------------------------
   localparam int SRC_LSB    = 4;
   localparam int SRC_MSB    = 7;
   localparam int REFF_BIT   = 3;
   localparam int FAMILY_BIT = 2;
   localparam int MULT_LSB   = 0;
   localparam int MULT_MSB   = 1;

   // Field positions of the status register.
   localparam int STS_VALID_BIT = 0;
   localparam int STS_DRIVE_BIT = 1;
   localparam int STS_LEVEL_BIT = 2;

   // Field positions of the identification register.
   localparam int ID_TYPE_LSB = 3;
   localparam int ID_REV_LSB  = 0;

   // ------------------------------------------------------------------
   // Values after reset.
   // ------------------------------------------------------------------
   localparam logic [7:0] CLK_CTRL_RST = 8'h00;
   localparam logic [7:0] LIU_RST_RST  = 8'h00;
   localparam logic [7:0] FRM_RST_RST  = 8'h00;

   // ------------------------------------------------------------------
   // Reference source codes and frequencies in kHz.
   // ------------------------------------------------------------------
   localparam logic [3:0]  SRC_DERIVED_T1 = 4'h8;
   localparam logic [3:0]  SRC_DERIVED_E1 = 4'h9;
   localparam logic [3:0]  SRC_EXTERNAL   = 4'ha;
   localparam logic [15:0] REF_E1_KHZ     = 16'h0800;
   localparam logic [15:0] REF_T1_KHZ     = 16'h0608;

   // Master clock base rates in kHz, shifted left by the multiple code.
   localparam logic [15:0] MCLK_E1_BASE_KHZ = 16'h0800;
   localparam logic [15:0] MCLK_T1_BASE_KHZ = 16'h0608;

   localparam int NUM_PORTS = 8;

   typedef enum logic [1:0] {
      GCR_SRC_NONE,
      GCR_SRC_PORT,
      GCR_SRC_DERIVED,
      GCR_SRC_EXTERNAL
   } gcr_src_t;

endpackage : gcr_pkg

// ---- rtl/gcr_sync2.sv ----
`timescale 1ns/100ps

module gcr_sync2 (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Asynchronous level in, synchronised level out
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_r;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : gcr_sync2

// ---- rtl/gcr_regs.sv ----
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps

module gcr_regs
   import gcr_pkg::*;
#(
   // Arbitrary neutral values, not those of any real part.
   parameter logic [4:0] DEVICE_TYPE = 5'h12,
   parameter logic [2:0] SILICON_REV = 3'h0
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Recovered receive clocks and master clock pin
   input  wire logic [7:0]  recovered_rx_clk,
   input  wire logic        master_clk_pin,
   // Reference clock pin, three signals
   input  wire logic        reference_clock_pin_i,
   output logic             reference_clock_pin_o,
   output logic             reference_clock_pin_oe_n,
   // Backplane clock generator controls
   output logic             backplane_ref_clk,
   output logic             backplane_ref_freq_sel,
   output logic             backplane_ref_valid,
   output logic [15:0]      master_clk_khz,
   // Per-port software resets
   output logic [7:0]       line_if_reset,
   output logic [7:0]       line_if_reset_start,
   output logic [7:0]       framer_tester_reset,
   output logic [7:0]       framer_tester_reset_start
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [7:0] rclk_s;
   logic       mclk_s;
   logic       refpin_s;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_rclk
         gcr_sync2 u_sync (
            .clk      (clk),
            .rst      (rst),
            .async_in (recovered_rx_clk[gi]),
            .sync_out (rclk_s[gi])
         );
      end
   endgenerate

   gcr_sync2 u_sync_mclk (
      .clk      (clk),
      .rst      (rst),
      .async_in (master_clk_pin),
      .sync_out (mclk_s)
   );

   gcr_sync2 u_sync_refpin (
      .clk      (clk),
      .rst      (rst),
      .async_in (reference_clock_pin_i),
      .sync_out (refpin_s)
   );

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   logic       ack_r;
   logic [7:0] reg_idx;
   logic       req;
   logic       wr_ack;
   logic       rd_take;
   logic       lane0;
   logic       hit_clk_ctrl;
   logic       hit_liu_rst;
   logic       hit_frm_rst;
   logic       hit_status;
   logic       hit_id;

   assign reg_idx      = avs_address[9:2];
   assign req          = avs_read | avs_write;
   assign lane0        = avs_byteenable[0];
   // Writes land at the edge where waitrequest is seen low.
   assign wr_ack       = avs_write & ack_r & lane0;
   assign rd_take      = avs_read & ~ack_r;
   assign hit_clk_ctrl = (reg_idx == IDX_CLK_CTRL);
   assign hit_liu_rst  = (reg_idx == IDX_LIU_RST);
   assign hit_frm_rst  = (reg_idx == IDX_FRM_RST);
   assign hit_status   = (reg_idx == IDX_STATUS);
   assign hit_id       = (reg_idx == IDX_ID);

   // One wait cycle per access gives time to register read data.
   assign avs_waitrequest = req & ~ack_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   logic [7:0] clk_ctrl_r;
   logic [7:0] clk_ctrl_nxt;
   logic [7:0] liu_rst_r;
   logic [7:0] liu_rst_nxt;
   logic [7:0] frm_rst_r;
   logic [7:0] frm_rst_nxt;

   assign clk_ctrl_nxt = (wr_ack & hit_clk_ctrl) ? avs_writedata[7:0]
                                                 : clk_ctrl_r;
   assign liu_rst_nxt  = (wr_ack & hit_liu_rst) ? avs_writedata[7:0]
                                                : liu_rst_r;
   assign frm_rst_nxt  = (wr_ack & hit_frm_rst) ? avs_writedata[7:0]
                                                : frm_rst_r;

   // identification write ignored
   // There is no storage behind the identification index, so a write
   // there falls through every decode above and changes no state.

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_ctrl_r <= CLK_CTRL_RST;
         liu_rst_r  <= LIU_RST_RST;
         frm_rst_r  <= FRM_RST_RST;
      end else begin
         clk_ctrl_r <= clk_ctrl_nxt;
         liu_rst_r  <= liu_rst_nxt;
         frm_rst_r  <= frm_rst_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Per-port software resets
   // ------------------------------------------------------------------
   logic [7:0] liu_rise;
   logic [7:0] frm_rise;

   assign liu_rise = liu_rst_nxt & ~liu_rst_r;
   assign frm_rise = frm_rst_nxt & ~frm_rst_r;

   assign line_if_reset       = liu_rst_r;
   assign framer_tester_reset = frm_rst_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_if_reset_start       <= 8'h00;
         framer_tester_reset_start <= 8'h00;
      end else begin
         line_if_reset_start       <= liu_rise;
         framer_tester_reset_start <= frm_rise;
      end
   end

   // ------------------------------------------------------------------
   // Reference source decode
   // ------------------------------------------------------------------
   logic [3:0] src_code;
   logic       ref_freq_t1;
   logic [2:0] port_sel;
   gcr_src_t   src_kind;

   assign src_code    = clk_ctrl_r[SRC_MSB:SRC_LSB];
   assign ref_freq_t1 = clk_ctrl_r[REFF_BIT];
   assign port_sel    = src_code[2:0];

   always_comb begin
      src_kind = GCR_SRC_NONE;
      if (!src_code[3]) begin
         src_kind = GCR_SRC_PORT;
      end else if (src_code == SRC_DERIVED_T1 && ref_freq_t1) begin
         src_kind = GCR_SRC_DERIVED;
      end else if (src_code == SRC_DERIVED_E1 && !ref_freq_t1) begin
         src_kind = GCR_SRC_DERIVED;
      end else if (src_code == SRC_EXTERNAL) begin
         src_kind = GCR_SRC_EXTERNAL;
      end
   end

   // ------------------------------------------------------------------
   // Master clock decode
   // ------------------------------------------------------------------
   logic [1:0]  mult_code;
   logic [15:0] mclk_base;
   logic [15:0] mclk_khz_nxt;
   logic [15:0] ref_khz;

   assign mult_code    = clk_ctrl_r[MULT_MSB:MULT_LSB];
   assign mclk_base    = clk_ctrl_r[FAMILY_BIT] ? MCLK_T1_BASE_KHZ
                                                : MCLK_E1_BASE_KHZ;
   assign mclk_khz_nxt = mclk_base << mult_code;
   assign ref_khz      = ref_freq_t1 ? REF_T1_KHZ : REF_E1_KHZ;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_clk_khz <= 16'h0000;
      end else begin
         master_clk_khz <= mclk_khz_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Reference derived from the master clock
   // ------------------------------------------------------------------
   // Every master clock transition adds the wanted rate to a phase
   // accumulator whose modulus is the master rate; each wrap toggles
   // the output. At most one toggle per transition, so a reference
   // faster than the master clock cannot be made and runs slow.
   logic        mclk_prev_r;
   logic        mclk_evt;
   logic [15:0] acc_r;
   logic [15:0] acc_nxt;
   logic [15:0] acc_sum;
   logic        acc_wrap;
   logic        derived_r;
   logic        derived_on;

   assign mclk_evt   = mclk_s ^ mclk_prev_r;
   assign derived_on = (src_kind == GCR_SRC_DERIVED);
   assign acc_sum    = acc_r + ref_khz;
   assign acc_wrap   = (acc_sum >= master_clk_khz);
   assign acc_nxt    = acc_wrap ? (acc_sum - master_clk_khz) : acc_sum;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mclk_prev_r <= 1'b0;
      end else begin
         mclk_prev_r <= mclk_s;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_r     <= 16'h0000;
         derived_r <= 1'b0;
      end else if (!derived_on) begin
         acc_r     <= 16'h0000;
         derived_r <= 1'b0;
      end else if (mclk_evt) begin
         acc_r     <= acc_nxt;
         derived_r <= derived_r ^ acc_wrap;
      end
   end

   // ------------------------------------------------------------------
   // Reference selection and pin direction
   // ------------------------------------------------------------------
   logic ref_level;
   logic pin_drive;

   always_comb begin
      ref_level = 1'b0;
      unique case (src_kind)
         GCR_SRC_NONE:     ref_level = 1'b0;
         GCR_SRC_PORT:     ref_level = rclk_s[port_sel];
         GCR_SRC_DERIVED:  ref_level = derived_r;
         GCR_SRC_EXTERNAL: ref_level = refpin_s;
      endcase
   end

   assign pin_drive                = derived_on;
   assign reference_clock_pin_o    = derived_r;
   assign reference_clock_pin_oe_n = ~pin_drive;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         backplane_ref_clk      <= 1'b0;
         backplane_ref_freq_sel <= 1'b0;
         backplane_ref_valid    <= 1'b0;
      end else begin
         backplane_ref_clk      <= ref_level;
         backplane_ref_freq_sel <= ref_freq_t1;
         backplane_ref_valid    <= (src_kind != GCR_SRC_NONE);
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   logic [7:0]  status_val;
   logic [7:0]  id_val;
   logic [31:0] rd_mux;

   always_comb begin
      status_val                = 8'h00;
      status_val[STS_VALID_BIT] = backplane_ref_valid;
      status_val[STS_DRIVE_BIT] = pin_drive;
      status_val[STS_LEVEL_BIT] = backplane_ref_clk;
   end

   assign id_val = {DEVICE_TYPE, SILICON_REV};

   assign rd_mux = hit_clk_ctrl ? {24'h000000, clk_ctrl_r} :
                   hit_liu_rst  ? {24'h000000, liu_rst_r}  :
                   hit_frm_rst  ? {24'h000000, frm_rst_r}  :
                   hit_status   ? {24'h000000, status_val} :
                   hit_id       ? {24'h000000, id_val}     :
                                  32'h00000000;

   // Read data is captured in the wait cycle and held until the next
   // read, so it is stable at the edge where the master takes it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_take) begin
         avs_readdata <= rd_mux;
      end
   end

endmodule : gcr_regs

// ---- verif/gcr_regs_monitor.sv ----
`timescale 1ns/100ps

// ---------------------------------------------------------------------
// Register bank checker
// ---------------------------------------------------------------------
module gcr_regs_monitor
   import gcr_pkg::*;
#(
   parameter logic [4:0] DEVICE_TYPE = 5'h12,
   parameter logic [2:0] SILICON_REV = 3'h0
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register bus
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Clock inputs and reference pin
   input wire logic [7:0]  recovered_rx_clk,
   input wire logic        master_clk_pin,
   input wire logic        reference_clock_pin_i,
   input wire logic        reference_clock_pin_o,
   input wire logic        reference_clock_pin_oe_n,
   // Generator controls
   input wire logic        backplane_ref_clk,
   input wire logic        backplane_ref_freq_sel,
   input wire logic        backplane_ref_valid,
   input wire logic [15:0] master_clk_khz,
   // Port resets
   input wire logic [7:0]  line_if_reset,
   input wire logic [7:0]  line_if_reset_start,
   input wire logic [7:0]  framer_tester_reset,
   input wire logic [7:0]  framer_tester_reset_start
);
   wire        wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
   wire [7:0]  idx   = avs_address[9:2];
   wire [7:0]  wd    = avs_writedata[7:0];
   wire        cc_wr = wr_ok && idx == IDX_CLK_CTRL;
   wire        drv   = (wd[7:4] == 4'h8 && wd[3]) ||
                       (wd[7:4] == 4'h9 && !wd[3]);
   wire        lst   = wd[7:4] < 4'h8 || wd[7:4] == 4'ha || drv;
   wire [15:0] khz   = (wd[2] ? MCLK_T1_BASE_KHZ : MCLK_E1_BASE_KHZ)
                       << wd[1:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_WAIT_ONE: assert property ((avs_read | avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("waitrequest longer than one cycle");
   AST_LIU_START: assert property (line_if_reset_start ==
      (line_if_reset & ~$past(line_if_reset))) else $error("line start bad");
   AST_LIU_VAL: assert property (wr_ok && idx == IDX_LIU_RST
      |=> line_if_reset == $past(wd)) else $error("line reset value bad");
   AST_LIU_HOLD: assert property (!$stable(line_if_reset)
      |-> $past(wr_ok && idx == IDX_LIU_RST)) else $error("line reset moved");
   AST_FRM_START: assert property (framer_tester_reset_start ==
      (framer_tester_reset & ~$past(framer_tester_reset)))
      else $error("framer start bad");
   AST_FRM_VAL: assert property (wr_ok && idx == IDX_FRM_RST
      |=> framer_tester_reset == $past(wd)) else $error("framer value bad");
   AST_PIN_DIR: assert property (cc_wr
      |=> reference_clock_pin_oe_n == !$past(drv)) else $error("pin dir bad");
   AST_FREQ: assert property (cc_wr
      |-> ##2 backplane_ref_freq_sel == $past(wd[3], 2))
      else $error("freq select bad");
   AST_VALID: assert property (cc_wr
      |-> ##2 backplane_ref_valid == $past(lst, 2)) else $error("valid bad");
   AST_MCLK: assert property (cc_wr
      |-> ##2 master_clk_khz == $past(khz, 2)) else $error("mclk decode bad");
   AST_ID: assert property (avs_read && !avs_waitrequest
      && idx == IDX_ID
      |-> avs_readdata == {24'h0, DEVICE_TYPE, SILICON_REV})
      else $error("id value bad");

   cover property (|line_if_reset_start);
   cover property (cc_wr && drv);
   cover property (avs_read && !avs_waitrequest && idx == IDX_ID);
endmodule : gcr_regs_monitor

bind gcr_regs gcr_regs_monitor #(
   .DEVICE_TYPE(DEVICE_TYPE), .SILICON_REV(SILICON_REV)
) u_mon (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .recovered_rx_clk(recovered_rx_clk),
   .master_clk_pin(master_clk_pin),
   .reference_clock_pin_i(reference_clock_pin_i),
   .reference_clock_pin_o(reference_clock_pin_o),
   .reference_clock_pin_oe_n(reference_clock_pin_oe_n),
   .backplane_ref_clk(backplane_ref_clk),
   .backplane_ref_freq_sel(backplane_ref_freq_sel),
   .backplane_ref_valid(backplane_ref_valid),
   .master_clk_khz(master_clk_khz), .line_if_reset(line_if_reset),
   .line_if_reset_start(line_if_reset_start),
   .framer_tester_reset(framer_tester_reset),
   .framer_tester_reset_start(framer_tester_reset_start)
);

// ---- verif/tb_gcr_regs.sv ----
`timescale 1ns/100ps

module tb_gcr_regs
   import gcr_pkg::*;
;
   // Arbitrary identity values, chosen only for this bench.
   localparam logic [4:0] TYPE = 5'h15;
   localparam logic [2:0] REV  = 3'h2;

   logic        clk = 1'b0, rst = 1'b1, rd_r = 1'b0, wr_r = 1'b0;
   logic [9:0]  adr = 10'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  be = 4'h0;
   logic [7:0]  rx = 8'h00;
   logic        refi = 1'b0;
   logic [2:0]  mclk = 3'h0;
   wire  [31:0] rdat;
   wire         wreq, pin_o, oe_n, bref, fsel, vld;
   wire  [15:0] khz;
   wire  [7:0]  lr, lrs, fr, frs;
   int          n_errors = 0, comparisons = 0;

   always #10 clk = ~clk;
   always @(posedge clk) mclk <= mclk + 3'h1;

   gcr_regs #(.DEVICE_TYPE(TYPE), .SILICON_REV(REV)) u_dut (
      .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_r),
      .avs_write(wr_r), .avs_writedata(wdat), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wreq),
      .recovered_rx_clk(rx), .master_clk_pin(mclk[2]),
      .reference_clock_pin_i(refi), .reference_clock_pin_o(pin_o),
      .reference_clock_pin_oe_n(oe_n), .backplane_ref_clk(bref),
      .backplane_ref_freq_sel(fsel), .backplane_ref_valid(vld),
      .master_clk_khz(khz), .line_if_reset(lr), .line_if_reset_start(lrs),
      .framer_tester_reset(fr), .framer_tester_reset_start(frs));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One access; the request is held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      input logic b, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      adr <= {ix, 2'b00};
      wdat <= {24'h0, d};
      be <= {3'b000, b};
      rd_r <= !w;
      wr_r <= w;
      @(negedge clk);
      while (wreq !== 1'b0) begin
         n++;
         if (n > 20) begin
            n_errors++;
            conclude();
         end
         @(negedge clk);
      end
      @(posedge clk);
      q = rdat;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, ix, d, 1'b1, q);
   endtask : wr

   function automatic logic [7:0] lvl(input logic [7:0] ix);
      return (ix == IDX_LIU_RST) ? lr : fr;
   endfunction : lvl

   function automatic logic [7:0] st(input logic [7:0] ix);
      return (ix == IDX_LIU_RST) ? lrs : frs;
   endfunction : st

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] q;
      check(32'({lr, fr, oe_n}), 32'h1);
      bus(1'b0, IDX_LIU_RST, 8'h00, 1'b1, q);
      check(q, 32'h0);
      bus(1'b0, IDX_FRM_RST, 8'h00, 1'b1, q);
      check(q, 32'h0);
   endtask : t_reset

   // Walks a set bit over all ports, then sets all and sets all again.
   task automatic t_soft(input logic [7:0] ix);
      logic [31:0] q;
      logic [7:0]  m, p;
      p = 8'h00;
      for (int i = 0; i < 10; i++) begin
         m = (i < 8) ? 8'h01 << i : 8'hff;
         wr(ix, m);
         #1;
         check(32'(lvl(ix)), 32'(m));
         check(32'(st(ix)), 32'(m & ~p));
         @(posedge clk);
         #1;
         check(32'({st(ix), lvl(ix)}), 32'({8'h00, m}));
         bus(1'b0, ix, 8'h00, 1'b1, q);
         check(q, 32'(m));
         p = m;
      end
      wr(ix, 8'h00);
      #1;
      check(32'(lvl(ix)), 32'h0);
   endtask : t_soft

   task automatic t_id();
      logic [31:0] q;
      wr(IDX_LIU_RST, 8'h5a);
      wr(IDX_ID, 8'hff);
      bus(1'b0, IDX_ID, 8'h00, 1'b1, q);
      check(q, {24'h0, TYPE, REV});
      bus(1'b1, IDX_LIU_RST, 8'h00, 1'b0, q);
      bus(1'b0, 8'h10, 8'h00, 1'b1, q);
      check(q, 32'h0);
      check(32'(lr), 32'h5a);
      wr(IDX_LIU_RST, 8'h00);
   endtask : t_id

   // Every valid pair of source code and frequency bit, and every master rate.
   task automatic t_clk();
      logic [31:0] q;
      logic [7:0]  d;
      logic        dv, ok;
      logic [15:0] mk;
      for (int c = 0; c < 32; c++) begin
         d = {c[4:0], c[1] ^ c[0], c[3:2]};
         d[3] = c[0];
         d[7:4] = c[4:1];
         dv = (d[7:4] == 4'h8 && d[3]) || (d[7:4] == 4'h9 && !d[3]);
         ok = d[7:4] < 4'h8 || d[7:4] == 4'ha || dv;
         if (!ok) continue;
         mk = (d[2] ? 16'h0608 : 16'h0800) << d[1:0];
         wr(IDX_CLK_CTRL, d);
         rx <= (d[7:4] < 4'h8) ? 8'h01 << d[6:4] : 8'h00;
         refi <= (d[7:4] == 4'ha);
         repeat (5) @(posedge clk);
         #1;
         check(32'({oe_n, vld, fsel}), 32'({!dv, ok, d[3]}));
         check(32'(khz), 32'(mk));
         if (!dv) check(32'(bref), 32'(ok));
         @(posedge clk);
         rx <= ~rx;
         refi <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         if (!dv) check(32'(bref), 32'h0);
         bus(1'b0, IDX_STATUS, 8'h00, 1'b1, q);
         check(32'(q[1:0]), 32'({dv, ok}));
         bus(1'b0, IDX_CLK_CTRL, 8'h00, 1'b1, q);
         check(q, 32'(d));
      end
   endtask : t_clk

   // The master rate is set to four times the reference, so the pin
   // must toggle once per four master transitions: 8 toggles over the
   // 32 transitions that fall in 128 cycles, whatever the phase.
   task automatic t_derived(input logic [7:0] d);
      int   n;
      logic prev;
      wr(IDX_CLK_CTRL, d);
      repeat (8) @(posedge clk);
      n = 0;
      prev = pin_o;
      repeat (128) begin
         @(posedge clk);
         #1;
         if (pin_o !== prev) n++;
         prev = pin_o;
      end
      check(32'(n), 32'h8);
      check(32'(oe_n), 32'h0);
   endtask : t_derived

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_soft(IDX_LIU_RST);
      t_soft(IDX_FRM_RST);
      t_id();
      t_clk();
      t_derived(8'h8e);
      t_derived(8'h92);
      wr(IDX_FRM_RST, 8'hff);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      t_reset();
      conclude();
   end
endmodule : tb_gcr_regs
